// ===== shared/rst_pwr_defines.vh
`ifndef RST_PWR_DEFINES_VH
`define RST_PWR_DEFINES_VH

// register map, register index times four gives the byte address
`define RPM_ADDR_W          12
`define RPM_PWRCTL_IDX      10'h087
`define RPM_STAT_IDX        10'h001
`define RPM_PWRCTL_ADDR     ({`RPM_PWRCTL_IDX, 2'b00})
`define RPM_STAT_ADDR       ({`RPM_STAT_IDX, 2'b00})

// power_control_reg fields
`define RPM_IDLE_BIT        0
`define RPM_PWRDN_BIT       1
`define RPM_UFLAG_LO_BIT    2
`define RPM_UFLAG_HI_BIT    3
`define RPM_BAUD_BIT        7
`define RPM_PWRCTL_RST      8'h00
`define RPM_PWRCTL_MASK_FULL 8'h8F
`define RPM_PWRCTL_MASK_BAUD 8'h80

// status register fields
`define RPM_ST_IDLE         0
`define RPM_ST_PWRDN        1
`define RPM_ST_HOLD         2
`define RPM_ST_IRST         3
`define RPM_ST_RAMBLK       4
`define RPM_ST_PVALID       5
`define RPM_ST_IRQOK        6

// AXI responses
`define RPM_RESP_OKAY       2'b00
`define RPM_RESP_SLVERR     2'b10

// timing: the core clock is the oscillator
`define RPM_CLK_NS          8
`define RPM_OSC_NS          8
`define RPM_MC_PERIODS      12
`define RPM_SAMPLE_PHASE    9
`define RPM_PORT_HOLD_OSC   19
`define RPM_PORT_HOLD_CYC   ((`RPM_PORT_HOLD_OSC * `RPM_OSC_NS) / `RPM_CLK_NS)

`endif

// ===== design/pin_sync.v
`timescale 1ns/100ps
module pin_sync (
  input  wire core_clk_in,
  input  wire rst_b_in,
  input  wire pin_in,
  output reg  level_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // level moves only once stages two and three agree
  always @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      s1_q      <= 1'b0;
      s2_q      <= 1'b0;
      s3_q      <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule // pin_sync

// ===== design/mcycle_timer.v
`timescale 1ns/100ps
module mcycle_timer #(
  parameter PERIODS      = 12,
  parameter SAMPLE_PHASE = 9
) (
  input  wire       core_clk_in,
  input  wire       rst_b_in,
  input  wire       run_in,
  output reg  [3:0] phase_out,
  output reg        sample_out
);
  localparam [3:0] LAST = PERIODS - 1;
  localparam [3:0] SMP  = SAMPLE_PHASE;

  // frozen while the oscillator is stopped
  always @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      phase_out  <= 4'h0;
      sample_out <= 1'b0;
    end else if (run_in) begin
      phase_out  <= (phase_out == LAST) ? 4'h0 : phase_out + 4'h1;
      sample_out <= (phase_out == SMP);
    end else begin
      sample_out <= 1'b0;
    end
  end
endmodule // mcycle_timer

// ===== design/reset_and_power_mode_control.v
// Overview of operation
// - reset pin sampled once per machine cycle at S5P2; only that sample starts reset.
// - after a sampled one, ports stay active 19 more oscillator periods.
// - internal reset zeros registers; port latches FFH, stack pointer 07H, serial buffer undefined.
// - reset never alters internal RAM; RAM undefined after power-up.
// - program counter, data pointer zero; priority, enable, power control cleared.
// - idle set by last instruction; CPU clock gated, peripherals keep clocking.
// - in idle CPU and pins hold, both strobes driven steady high.
// - enabled interrupt clears idle bit in hardware and ends idle.
// - high reset level clears idle at once; CPU runs until reset takes over.
// - between idle exit by reset and internal reset, block RAM, not ports.
// - power-down bit freezes oscillator, stopping all clocked activity.
// - power_control_reg decoded at index 87H; its bits activate power modes.
// - user flags at bits 3 and 2 are plain read/write bits.
// - bit 7 is baud select; without power modes it is the only bit.
// - ports undefined after power-up until internal reset has set latches.
// - after interrupt return, one instruction runs before another interrupt.
// - power-down left only by hardware reset, which restarts the oscillator.
// - in power-down both strobes driven low, ports keep latch values.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "rst_pwr_defines.vh"
module reset_and_power_mode_control #(
  parameter POWER_MODES = 1
) (
  input  wire                  core_clk_in,
  input  wire                  rst_b_in,
  input  wire                  s_axi_awvalid_in,
  output reg                   s_axi_awready_out,
  input  wire [`RPM_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire                  s_axi_wvalid_in,
  output reg                   s_axi_wready_out,
  input  wire [31:0]           s_axi_wdata_in,
  input  wire [3:0]            s_axi_wstrb_in,
  output reg                   s_axi_bvalid_out,
  input  wire                  s_axi_bready_in,
  output reg  [1:0]            s_axi_bresp_out,
  input  wire                  s_axi_arvalid_in,
  output reg                   s_axi_arready_out,
  input  wire [`RPM_ADDR_W-1:0] s_axi_araddr_in,
  output reg                   s_axi_rvalid_out,
  input  wire                  s_axi_rready_in,
  output reg  [31:0]           s_axi_rdata_out,
  output reg  [1:0]            s_axi_rresp_out,
  input  wire                  rst_pin_in,
  input  wire                  irq_wake_in,
  input  wire                  irq_return_in,
  input  wire                  instr_done_in,
  output reg                   cpu_clk_en_out,
  output reg                   periph_clk_en_out,
  output reg                   osc_run_out,
  output reg                   int_reset_out,
  output reg                   port_reset_out,
  output reg                   port_valid_out,
  output reg                   ram_block_out,
  output reg                   strobe_force_out,
  output reg                   strobe_level_out,
  output reg                   baud_double_out,
  output reg                   irq_accept_ok_out
);
  localparam [4:0] ST_RUN  = 5'b00001;
  localparam [4:0] ST_IDLE = 5'b00010;
  localparam [4:0] ST_PWRDN = 5'b00100;
  localparam [4:0] ST_HOLD = 5'b01000;
  localparam [4:0] ST_IRST = 5'b10000;

  localparam [7:0] PWRCTL_MASK = POWER_MODES ? `RPM_PWRCTL_MASK_FULL : `RPM_PWRCTL_MASK_BAUD;
  localparam [4:0] HOLD_LAST = `RPM_PORT_HOLD_CYC - 1;

  wire       rst_lvl;
  wire       smp;
  reg  [4:0] state_q;
  reg  [4:0] state_d;
  reg  [4:0] cnt_q;
  reg  [4:0] cnt_d;
  reg  [7:0] pwrctl_q;
  reg  [7:0] pwrctl_d;
  reg        ram_blk_q;
  reg        ram_blk_d;
  reg        pvalid_q;
  reg        pvalid_d;

  reg                   aw_have_q;
  reg                   w_have_q;
  reg [`RPM_ADDR_W-1:0] awaddr_q;
  reg [7:0]             wbyte_q;
  reg                   wlane0_q;
  wire                  wr_fire;
  wire                  wr_pwrctl;
  wire                  wr_hit;
  wire [7:0]            status;

  pin_sync u_rst_sync (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .pin_in      (rst_pin_in),
    .level_out   (rst_lvl)
  );

  // sample strobe stops with the oscillator
  mcycle_timer #(
    .PERIODS      (`RPM_MC_PERIODS),
    .SAMPLE_PHASE (`RPM_SAMPLE_PHASE)
  ) u_mcycle (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .run_in      (osc_run_out),
    .phase_out   (),
    .sample_out  (smp)
  );

  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid_out;
  assign wr_hit  = (awaddr_q == `RPM_PWRCTL_ADDR) || (awaddr_q == `RPM_STAT_ADDR);
  assign wr_pwrctl = wr_fire & (awaddr_q == `RPM_PWRCTL_ADDR) & wlane0_q;

  assign status = {1'b0,
                   irq_accept_ok_out,
                   pvalid_q,
                   ram_blk_q,
                   state_q == ST_IRST,
                   state_q == ST_HOLD,
                   state_q == ST_PWRDN,
                   state_q == ST_IDLE};

  always @* begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    pwrctl_d  = pwrctl_q;
    ram_blk_d = ram_blk_q;
    pvalid_d  = pvalid_q;
    // writes are ignored while the internal reset owns the register
    if (wr_pwrctl && state_q != ST_IRST) begin
      pwrctl_d = wbyte_q & PWRCTL_MASK;
    end
    case (state_q)
      ST_RUN: begin
        if (smp && rst_lvl) begin
          state_d = ST_HOLD;
          cnt_d   = HOLD_LAST;
        end else if (pwrctl_q[`RPM_PWRDN_BIT]) begin
          state_d = ST_PWRDN;
        end else if (pwrctl_q[`RPM_IDLE_BIT]) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (rst_lvl) begin
          state_d   = ST_RUN;
          ram_blk_d = 1'b1;
        end else if (irq_wake_in) begin
          state_d = ST_RUN;
          pwrctl_d[`RPM_IDLE_BIT] = 1'b0;
        end
      end
      ST_PWRDN: begin
        if (rst_lvl) begin
          state_d = ST_RUN;
          pwrctl_d[`RPM_PWRDN_BIT] = 1'b0;
        end
      end
      ST_HOLD: begin
        // ports keep running until the countdown ends
        if (cnt_q == 5'd0) begin
          state_d = ST_IRST;
        end else begin
          cnt_d = cnt_q - 5'd1;
        end
      end
      ST_IRST: begin
        pwrctl_d = `RPM_PWRCTL_RST;
        ram_blk_d = 1'b0;
        if (smp && !rst_lvl) begin
          state_d  = ST_RUN;
          pvalid_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    if (rst_lvl) begin
      pwrctl_d[`RPM_IDLE_BIT] = 1'b0;
    end
  end

  always @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      state_q           <= ST_RUN;
      cnt_q             <= 5'd0;
      pwrctl_q          <= `RPM_PWRCTL_RST;
      ram_blk_q         <= 1'b0;
      pvalid_q          <= 1'b0;
      cpu_clk_en_out    <= 1'b1;
      periph_clk_en_out <= 1'b1;
      osc_run_out       <= 1'b1;
      int_reset_out     <= 1'b0;
      port_reset_out    <= 1'b0;
      port_valid_out    <= 1'b0;
      ram_block_out     <= 1'b0;
      strobe_force_out  <= 1'b0;
      strobe_level_out  <= 1'b0;
      baud_double_out   <= 1'b0;
    end else begin
      state_q           <= state_d;
      cnt_q             <= cnt_d;
      pwrctl_q          <= pwrctl_d;
      ram_blk_q         <= ram_blk_d;
      pvalid_q          <= pvalid_d;
      cpu_clk_en_out    <= ~(state_d == ST_IDLE || state_d == ST_PWRDN);
      periph_clk_en_out <= (state_d != ST_PWRDN);
      osc_run_out       <= (state_d != ST_PWRDN);
      // core loads its reset values, RAM is left alone
      int_reset_out     <= (state_d == ST_IRST);
      port_reset_out    <= (state_d == ST_IRST);
      port_valid_out    <= pvalid_d;
      ram_block_out     <= ram_blk_d;
      strobe_force_out  <= (state_d == ST_IDLE || state_d == ST_PWRDN);
      strobe_level_out  <= (state_d == ST_IDLE);
      baud_double_out   <= pwrctl_d[`RPM_BAUD_BIT];
    end
  end

  // return blocks acceptance until one more instruction completes
  always @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      irq_accept_ok_out <= 1'b1;
    end else if (irq_return_in) begin
      irq_accept_ok_out <= 1'b0;
    end else if (instr_done_in) begin
      irq_accept_ok_out <= 1'b1;
    end
  end

  // write channel: address and data taken in either order
  always @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      aw_have_q         <= 1'b0;
      w_have_q          <= 1'b0;
      awaddr_q          <= {`RPM_ADDR_W{1'b0}};
      wbyte_q           <= 8'h00;
      wlane0_q          <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `RPM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_q         <= 1'b1;
        awaddr_q          <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_q         <= 1'b1;
        wbyte_q          <= s_axi_wdata_in[7:0];
        wlane0_q         <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q        <= 1'b0;
        w_have_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_hit ? `RPM_RESP_OKAY : `RPM_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // read channel
  always @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `RPM_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      if (s_axi_araddr_in == `RPM_PWRCTL_ADDR) begin
        s_axi_rdata_out <= {24'h00_0000, pwrctl_q};
        s_axi_rresp_out <= `RPM_RESP_OKAY;
      end else if (s_axi_araddr_in == `RPM_STAT_ADDR) begin
        s_axi_rdata_out <= {24'h00_0000, status};
        s_axi_rresp_out <= `RPM_RESP_OKAY;
      end else begin
        s_axi_rdata_out <= 32'h0000_0000;
        s_axi_rresp_out <= `RPM_RESP_SLVERR;
      end
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end
endmodule // reset_and_power_mode_control

// ===== tb/rpm_checker_sva.sv
`timescale 1ns/100ps
module rpm_checker (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic rst_pin_in,
  input wire logic irq_wake_in,
  input wire logic irq_return_in,
  input wire logic instr_done_in,
  input wire logic cpu_clk_en_out,
  input wire logic periph_clk_en_out,
  input wire logic osc_run_out,
  input wire logic int_reset_out,
  input wire logic port_reset_out,
  input wire logic ram_block_out,
  input wire logic strobe_force_out,
  input wire logic strobe_level_out,
  input wire logic irq_accept_ok_out
);
  wire idle_w = !cpu_clk_en_out && periph_clk_en_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_idle_strobes_high: assert property (idle_w |-> strobe_force_out && strobe_level_out)
    else $error("idle without high strobes");
  a_pwrdn_all_frozen: assert property (!osc_run_out |-> !cpu_clk_en_out && !periph_clk_en_out
    && strobe_force_out && !strobe_level_out) else $error("power-down outputs wrong");
  a_port_latch_reset: assert property (port_reset_out == int_reset_out)
    else $error("port reset apart from internal reset");
  a_return_blocks_irq: assert property (irq_return_in |=> !irq_accept_ok_out)
    else $error("irq accepted right after return");
  a_step_reopens_irq: assert property (!irq_accept_ok_out && instr_done_in && !irq_return_in
    |=> irq_accept_ok_out) else $error("irq not reopened after one instruction");
  a_wake_ends_idle: assert property (idle_w && irq_wake_in |-> ##[1:3] cpu_clk_en_out)
    else $error("interrupt did not end idle");
  a_pin_ends_idle: assert property (idle_w && rst_pin_in |-> ##[1:8] cpu_clk_en_out)
    else $error("reset pin did not end idle");
  a_ram_block_cause: assert property ($rose(ram_block_out) |-> $past(idle_w) || $past(idle_w, 2))
    else $error("ram blocked outside idle exit");
  a_irst_after_hold: assert property ($rose(int_reset_out) |-> $past(rst_pin_in, 20))
    else $error("internal reset too early");
  a_pwrdn_irq_ignored: assert property (!osc_run_out && !rst_pin_in && !$past(rst_pin_in, 4)
    |=> !osc_run_out) else $error("power-down left without reset");
  a_pwrdn_exit_by_pin: assert property (!osc_run_out && rst_pin_in |-> ##[1:8] osc_run_out)
    else $error("reset did not restart oscillator");
  a_resp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped");
  c_idle: cover property (idle_w);
  c_power_down: cover property (!osc_run_out);
  c_int_reset: cover property ($rose(int_reset_out));
endmodule // rpm_checker

bind reset_and_power_mode_control rpm_checker u_rpm_checker (.core_clk_in, .rst_b_in,
  .s_axi_bvalid_out, .s_axi_bready_in, .rst_pin_in, .irq_wake_in, .irq_return_in, .instr_done_in,
  .cpu_clk_en_out, .periph_clk_en_out, .osc_run_out, .int_reset_out, .port_reset_out,
  .ram_block_out, .strobe_force_out, .strobe_level_out, .irq_accept_ok_out);

// ===== tb/far_side_model.sv
`timescale 1ns/100ps
module far_side_model (
  input  wire       core_clk_in,
  input  wire       pulse_go_in,
  input  wire [7:0] pulse_len_in,
  input  wire       cpu_clk_en_in,
  output wire       rst_pin_out,
  output reg        instr_done_out
);
  reg [7:0] hold_q;
  reg [1:0] step_q;
  initial begin
    hold_q = 8'h00;
    step_q = 2'h0;
    instr_done_out = 1'b0;
  end
  assign rst_pin_out = (hold_q != 8'h00);
  always @(posedge core_clk_in) begin
    if (pulse_go_in && hold_q == 8'h00)
      hold_q <= (pulse_len_in < 8'h18) ? 8'h18 : pulse_len_in;
    else if (hold_q != 8'h00)
      hold_q <= hold_q - 8'h01;
    // nothing retires while the cpu clock is gated
    if (cpu_clk_en_in)
      step_q <= step_q + 2'h1;
    instr_done_out <= cpu_clk_en_in && (step_q == 2'h3);
  end
endmodule // far_side_model

// ===== tb/testbench.sv
`timescale 1ns/100ps
`include "rst_pwr_defines.vh"
module testbench;
  logic core_clk_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, irq_wake_in, irq_return_in, pulse_go;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, d;
  logic [3:0] s_axi_wstrb_in;
  logic [7:0] pulse_len, v;
  logic [1:0] r;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire cpu_clk_en_out, periph_clk_en_out, osc_run_out, int_reset_out, port_reset_out;
  wire port_valid_out, ram_block_out, strobe_force_out, strobe_level_out, baud_double_out;
  wire irq_accept_ok_out, rst_pin_in, instr_done_in;
  integer seed;
  int error_cnt, compares, i, n;

  reset_and_power_mode_control u_reset_and_power_mode_control (.core_clk_in, .rst_b_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .s_axi_rresp_out, .rst_pin_in, .irq_wake_in, .irq_return_in, .instr_done_in,
    .cpu_clk_en_out, .periph_clk_en_out, .osc_run_out, .int_reset_out, .port_reset_out,
    .port_valid_out, .ram_block_out, .strobe_force_out, .strobe_level_out, .baud_double_out,
    .irq_accept_ok_out);
  far_side_model u_far_side_model (.core_clk_in, .pulse_go_in(pulse_go),
    .pulse_len_in(pulse_len), .cpu_clk_en_in(cpu_clk_en_out), .rst_pin_out(rst_pin_in),
    .instr_done_out(instr_done_in));

  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [7:0] wd, input logic [1:0] er);
    logic pa, pw;
    int k;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h000000, wd};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    for (k = 0; k < 50 && (pa || pw); k++) begin
      @(posedge core_clk_in);
      if (pa && s_axi_awready_out) begin
        pa = 1'b0;
        s_axi_awvalid_in <= 1'b0;
      end
      if (pw && s_axi_wready_out) begin
        pw = 1'b0;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    s_axi_bready_in <= 1'b1;
    for (k = 0; k < 50 && !s_axi_bvalid_out; k++) @(posedge core_clk_in);
    chk(s_axi_bresp_out, er);
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int k;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge core_clk_in);
      if (s_axi_arready_out) break;
    end
    s_axi_arvalid_in <= 1'b0;
    s_axi_rready_in <= 1'b1;
    for (k = 0; k < 50 && !s_axi_rvalid_out; k++) @(posedge core_clk_in);
    d = s_axi_rdata_out;
    chk(s_axi_rresp_out, er);
    if (exp !== 32'hFFFFFFFF) chk(d, exp);
    s_axi_rready_in <= 1'b0;
  endtask

  // pin held 24 to 39 clocks; length drawn at random
  task automatic pin_pulse;
    pulse_len <= 8'h18 + (8'($random(seed)) & 8'h0F);
    pulse_go <= 1'b1;
    @(posedge core_clk_in);
    pulse_go <= 1'b0;
    for (n = 0; n < 200 && !int_reset_out; n++) @(posedge core_clk_in);
    chk(port_reset_out, 1'b1);
    @(posedge core_clk_in);
    chk(ram_block_out, 1'b0);
    for (n = 0; n < 200 && int_reset_out; n++) @(posedge core_clk_in);
    chk(port_valid_out, 1'b1);
    rd_chk(`RPM_PWRCTL_ADDR, 32'h0, `RPM_RESP_OKAY);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    seed = 32'hd9c0;
    {rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 5'h00;
    {s_axi_rready_in, irq_wake_in, irq_return_in, pulse_go} = 4'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 56'h0;
    s_axi_wstrb_in = 4'hF;
    pulse_len = 8'h18;
    repeat (2) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    @(posedge core_clk_in);
    chk(port_valid_out, 1'b0);
    rd_chk(`RPM_PWRCTL_ADDR, 32'h0, `RPM_RESP_OKAY);
    rd_chk(12'h100, 32'h0, `RPM_RESP_SLVERR);
    axi_wr(12'h100, 8'h8C, `RPM_RESP_SLVERR);
    for (i = 0; i < 16; i++) begin
      v = 8'($random(seed)) & `RPM_PWRCTL_MASK_FULL & 8'hFC;
      irq_wake_in <= $random(seed);
      irq_return_in <= $random(seed);
      axi_wr(`RPM_PWRCTL_ADDR, v, `RPM_RESP_OKAY);
      rd_chk(`RPM_PWRCTL_ADDR, {24'h0, v}, `RPM_RESP_OKAY);
      chk(baud_double_out, v[7]);
    end
    {irq_wake_in, irq_return_in} <= 2'b00;
    pin_pulse;
    rd_chk(`RPM_STAT_ADDR, 32'hFFFFFFFF, `RPM_RESP_OKAY);
    chk(d & 32'h3F, 32'h20);
    axi_wr(`RPM_PWRCTL_ADDR, 8'h05, `RPM_RESP_OKAY);
    for (n = 0; n < 20 && cpu_clk_en_out; n++) @(posedge core_clk_in);
    repeat (20) @(posedge core_clk_in);
    chk({cpu_clk_en_out, periph_clk_en_out, osc_run_out}, 3'b011);
    chk({strobe_force_out, strobe_level_out}, 2'b11);
    irq_wake_in <= 1'b1;
    for (n = 0; n < 20 && !cpu_clk_en_out; n++) @(posedge core_clk_in);
    irq_wake_in <= 1'b0;
    rd_chk(`RPM_PWRCTL_ADDR, 32'h04, `RPM_RESP_OKAY);
    // three retired steps after wake, as software places no-ops there
    for (n = 0; n < 3; n++) @(posedge core_clk_in iff instr_done_in);
    axi_wr(`RPM_PWRCTL_ADDR, 8'h01, `RPM_RESP_OKAY);
    for (n = 0; n < 20 && cpu_clk_en_out; n++) @(posedge core_clk_in);
    pulse_go <= 1'b1;
    @(posedge core_clk_in);
    for (n = 0; n < 20 && !cpu_clk_en_out; n++) @(posedge core_clk_in);
    chk(ram_block_out, 1'b1);
    pin_pulse;
    axi_wr(`RPM_PWRCTL_ADDR, 8'h03, `RPM_RESP_OKAY);
    for (n = 0; n < 20 && osc_run_out; n++) @(posedge core_clk_in);
    irq_wake_in <= 1'b1;
    repeat (30) @(posedge core_clk_in);
    chk({osc_run_out, cpu_clk_en_out, periph_clk_en_out}, 3'b000);
    chk({strobe_force_out, strobe_level_out}, 2'b10);
    irq_wake_in <= 1'b0;
    pin_pulse;
    irq_return_in <= 1'b1;
    @(posedge core_clk_in);
    irq_return_in <= 1'b0;
    @(posedge core_clk_in);
    chk(irq_accept_ok_out, 1'b0);
    for (n = 0; n < 20 && !irq_accept_ok_out; n++) @(posedge core_clk_in);
    chk(irq_accept_ok_out, 1'b1);
    tally_and_finish;
  end
endmodule // testbench
